//--- halt_wake_pkg.sv
// Package: register map, field layout, reset values and timing for halt_mode_wake_control
package halt_wake_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_SYSCTL = 12'h000;  // system_control_one
  localparam logic [11:0] OFS_WARMUP = 12'h004;  // warmup_control_reg
  localparam logic [11:0] OFS_WAKECFG = 12'h008; // key and voltage release setup
  localparam logic [11:0] OFS_STATUS = 12'h00C;  // read-only state

  // ----------------------------------------------------------------
  // system_control_one fields
  // ----------------------------------------------------------------
  localparam int BIT_HALT_REQ = 7;   // write 1 to halt
  localparam int BIT_RELEASE_MODE_SELECT = 6;       // release_mode_select
  localparam int BIT_OUTHOLD = 5;    // port_output_hold_select
  localparam int LSB_RUNMODE = 0;    // run mode, two bits
  localparam logic RELEASE_MODE_SELECT_LEVEL = 1'b1;
  localparam logic RELEASE_MODE_SELECT_EDGE = 1'b0;

  // ----------------------------------------------------------------
  // warmup_control_reg fields
  // ----------------------------------------------------------------
  localparam int LSB_WARM_CNT = 0;   // warm-up count, WARM_W bits
  localparam int BIT_WARM_SRC = 16;  // warmup_source_select, 1 = low-frequency

  // ----------------------------------------------------------------
  // Wake configuration fields
  // ----------------------------------------------------------------
  localparam int BIT_KEY_EN = 0;     // key-on wakeup enabled
  localparam int BIT_KEY_LVL = 1;    // releasing key level, 1 = high
  localparam int BIT_VD_RST = 2;     // voltage detector generates reset

  // ----------------------------------------------------------------
  // Run modes and controller states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    single_clock_high_run,
    dual_clock_high_run,
    dual_clock_low_run
  } run_mode_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT,
    ST_VRST,
    ST_WARM
  } hstate_t;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] WARM_CNT_RST = 16'h00FF; // plain default count
  localparam int PCLK_HZ = 25_000_000;              // pclk rate
  localparam int MC_PCLK = 4;                       // pclk cycles per machine cycle
  localparam logic [31:0] PC_STEP = 32'h0000_0002;  // halted PC offset, in words
endpackage

//--- halt_mode_wake_control.sv
// Halt mode entry, wake release and warm-up sequencing with an APB register port
//
// Behaviour
// - Writing halt bit one enters halt
// - Halt stops both oscillators and core
// - State held; port hold per select bit
// - Entry clears prescaler and divider
// - Halted PC is request address plus two
// - Resets end halt; resume single-clock high
// - Wake pin, key, voltage detector release
// - Level mode: high wake pin releases
// - Level mode: request ignored while pin high
// - Level mode: pin low after release harmless
// - Edge mode: rising wake edge releases
// - Edge mode: request taken while pin high
// - Edge within one machine cycle ignored
// - Key level, high or low, releases
// - Key leaving level after release harmless
// - Voltage low: immediate release and reset
// - Recovery within one machine cycle ignored
// - Oscillator restart, then warm-up, then run
// - Resume next instruction; clear timing generator
// - Warm-up source follows entry clock
// - Single: high only; dual high: both
// - Dual low: low oscillator only
//
// Decided for this implementation: the APB slave port and the register addresses.
module halt_mode_wake_control #(
  parameter int WARM_W = 16,   // warm-up counter width
  parameter int PC_W = 16,     // program counter width
  parameter int MC_DIV = halt_wake_pkg::MC_PCLK
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Release sources, asynchronous
  input wire logic wake_pin,
  input wire logic key_pin,
  input wire logic vd_low,
  // Core interface
  input wire logic [PC_W-1:0] req_pc,
  output logic [PC_W-1:0] resume_pc,
  output logic core_run,
  output logic tg_clear,
  output logic port_hold,
  // Oscillator control
  output logic hf_osc_en,
  output logic lf_osc_en,
  output logic warm_src_lf,
  // Voltage detection reset out
  output logic vd_reset
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (WARM_W < 1 || WARM_W > 16) begin : g_chk_warm
    $error("WARM_W must be 1..16");
  end
  if (MC_DIV < 2 || MC_DIV > 255) begin : g_chk_mc
    $error("MC_DIV must be 2..255");
  end
  if (PC_W < 2 || PC_W > 32) begin : g_chk_pc
    $error("PC_W must be 2..32");
  end

  // ----------------------------------------------------------------
  // Module state
  // ----------------------------------------------------------------
  typedef struct packed {
    halt_wake_pkg::hstate_t st;           // controller state
    halt_wake_pkg::run_mode_t mode;       // current run mode
    halt_wake_pkg::run_mode_t entry_mode; // mode saved on entry
    logic release_mode_select;                           // release_mode_select
    logic out_hold;                       // port_output_hold_select
    logic [WARM_W-1:0] warm_cnt;          // programmed warm-up count
    logic warm_sel;                       // warmup_source_select
    logic key_en;                         // key wakeup enable
    logic key_lvl;                        // key releasing level
    logic vd_rst_en;                      // voltage reset generation
    logic [2:0] wake_s;                   // wake sync, last bit is history
    logic [1:0] key_s;                    // key sync
    logic [1:0] vd_s;                     // voltage sync
    logic [7:0] mc_cnt;                   // machine cycle divider
    logic blank;                          // first machine cycle after request
    logic [7:0] blank_cnt;                // pclk count of the blank window
    logic [WARM_W-1:0] warm_left;         // warm-up remaining
    logic after_vrst;                     // warm-up follows a voltage reset
    logic [PC_W-1:0] resume_pc;
    logic core_run;
    logic tg_clear;
    logic port_hold;
    logic hf_en;
    logic lf_en;
    logic src_lf;
    logic vd_reset;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address decode, shared by read and write paths
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    case (a)
      halt_wake_pkg::OFS_SYSCTL: reg_sel = 3'h1;
      halt_wake_pkg::OFS_WARMUP: reg_sel = 3'h2;
      halt_wake_pkg::OFS_WAKECFG: reg_sel = 3'h3;
      halt_wake_pkg::OFS_STATUS: reg_sel = 3'h4;
      default: reg_sel = 3'h0;
    endcase
  endfunction

  // Oscillators to start on release, by entry mode
  function automatic logic [1:0] osc_for(input halt_wake_pkg::run_mode_t m);
    case (m)
      halt_wake_pkg::dual_clock_high_run: osc_for = 2'b11;
      halt_wake_pkg::dual_clock_low_run: osc_for = 2'b01;
      default: osc_for = 2'b10;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic wr;
    logic rd_setup;
    logic halt_wr;
    logic wake_hi;
    logic wake_rise;
    logic key_hit;
    logic vd_lo;
    logic release_ev;
    logic [1:0] osc;
    wr = 1'b0;
    rd_setup = 1'b0;
    halt_wr = 1'b0;
    wake_hi = 1'b0;
    wake_rise = 1'b0;
    key_hit = 1'b0;
    vd_lo = 1'b0;
    release_ev = 1'b0;
    osc = 2'b00;
    s_nxt = s_r;

    // Two-flop synchronisers; stage 0 feeds stage 1 only
    s_nxt.wake_s = {s_r.wake_s[1], s_r.wake_s[0], wake_pin};
    s_nxt.key_s = {s_r.key_s[0], key_pin};
    s_nxt.vd_s = {s_r.vd_s[0], vd_low};
    wake_hi = s_r.wake_s[1];
    wake_rise = s_r.wake_s[1] & ~s_r.wake_s[2];
    key_hit = s_r.key_en & (s_r.key_s[1] == s_r.key_lvl);
    vd_lo = s_r.vd_s[1];

    // Free-running machine cycle divider
    s_nxt.mc_cnt = (s_r.mc_cnt == 8'(MC_DIV - 1)) ? 8'h00 : s_r.mc_cnt + 8'h01;

    // Blanking window of one machine cycle after a request
    if (s_r.blank) begin
      if (s_r.blank_cnt == 8'(MC_DIV - 1)) begin
        s_nxt.blank = 1'b0;
      end else begin
        s_nxt.blank_cnt = s_r.blank_cnt + 8'h01;
      end
    end

    // Default pulse outputs
    s_nxt.tg_clear = 1'b0;

    // APB: ready one cycle after setup; write at the access edge
    s_nxt.pready = psel & ~penable;
    wr = psel & penable & s_r.pready & pwrite;
    rd_setup = psel & ~penable;
    if (rd_setup) begin
      // Read data and error captured in setup, stable through access
      s_nxt.pslverr = (reg_sel(paddr) == 3'h0);
      s_nxt.prdata = 32'h0000_0000;
      case (reg_sel(paddr))
        3'h1: begin
          s_nxt.prdata[halt_wake_pkg::BIT_HALT_REQ] = (s_r.st != halt_wake_pkg::ST_RUN);
          s_nxt.prdata[halt_wake_pkg::BIT_RELEASE_MODE_SELECT] = s_r.release_mode_select;
          s_nxt.prdata[halt_wake_pkg::BIT_OUTHOLD] = s_r.out_hold;
          s_nxt.prdata[halt_wake_pkg::LSB_RUNMODE +: 2] = s_r.mode;
        end
        3'h2: begin
          s_nxt.prdata[halt_wake_pkg::LSB_WARM_CNT +: WARM_W] = s_r.warm_cnt;
          s_nxt.prdata[halt_wake_pkg::BIT_WARM_SRC] = s_r.warm_sel;
        end
        3'h3: begin
          s_nxt.prdata[halt_wake_pkg::BIT_KEY_EN] = s_r.key_en;
          s_nxt.prdata[halt_wake_pkg::BIT_KEY_LVL] = s_r.key_lvl;
          s_nxt.prdata[halt_wake_pkg::BIT_VD_RST] = s_r.vd_rst_en;
        end
        3'h4: begin
          // Live state: pins, oscillators, core
          s_nxt.prdata[2:0] = 3'(s_r.st);
          s_nxt.prdata[4] = wake_hi;
          s_nxt.prdata[5] = s_r.key_s[1];
          s_nxt.prdata[6] = vd_lo;
          s_nxt.prdata[8] = s_r.hf_en;
          s_nxt.prdata[9] = s_r.lf_en;
          s_nxt.prdata[10] = s_r.core_run;
        end
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
    end

    // Register writes; only while the core runs, since a halted core writes nothing
    if (wr && s_r.st == halt_wake_pkg::ST_RUN) begin
      case (reg_sel(paddr))
        3'h1: begin
          s_nxt.release_mode_select = pwdata[halt_wake_pkg::BIT_RELEASE_MODE_SELECT];
          s_nxt.out_hold = pwdata[halt_wake_pkg::BIT_OUTHOLD];
          s_nxt.mode = halt_wake_pkg::run_mode_t'(pwdata[halt_wake_pkg::LSB_RUNMODE +: 2]);
          halt_wr = pwdata[halt_wake_pkg::BIT_HALT_REQ];
        end
        3'h2: begin
          s_nxt.warm_cnt = pwdata[halt_wake_pkg::LSB_WARM_CNT +: WARM_W];
          s_nxt.warm_sel = pwdata[halt_wake_pkg::BIT_WARM_SRC];
        end
        3'h3: begin
          s_nxt.key_en = pwdata[halt_wake_pkg::BIT_KEY_EN];
          s_nxt.key_lvl = pwdata[halt_wake_pkg::BIT_KEY_LVL];
          s_nxt.vd_rst_en = pwdata[halt_wake_pkg::BIT_VD_RST];
        end
        default: s_nxt.pslverr = s_r.pslverr;
      endcase
    end

    // Halt controller
    case (s_r.st)
      halt_wake_pkg::ST_RUN: begin
        s_nxt.src_lf = s_r.warm_sel;
        // Level mode refuses entry while the pin is high; edge mode does not
        if (halt_wr && !(pwdata[halt_wake_pkg::BIT_RELEASE_MODE_SELECT] == halt_wake_pkg::RELEASE_MODE_SELECT_LEVEL
            && wake_hi)) begin
          s_nxt.st = halt_wake_pkg::ST_HALT;
          s_nxt.entry_mode = halt_wake_pkg::run_mode_t'(
              pwdata[halt_wake_pkg::LSB_RUNMODE +: 2]);
          s_nxt.hf_en = 1'b0;
          s_nxt.lf_en = 1'b0;
          s_nxt.core_run = 1'b0;
          s_nxt.tg_clear = 1'b1;
          s_nxt.port_hold = pwdata[halt_wake_pkg::BIT_OUTHOLD];
          s_nxt.resume_pc = req_pc + PC_W'(halt_wake_pkg::PC_STEP);
          s_nxt.blank = 1'b1;
          s_nxt.blank_cnt = 8'h00;
        end
      end
      halt_wake_pkg::ST_HALT: begin
        // Voltage reset overrides every other source at once
        if (s_r.vd_rst_en && vd_lo) begin
          s_nxt.st = halt_wake_pkg::ST_VRST;
          s_nxt.vd_reset = 1'b1;
        end else begin
          if (s_r.release_mode_select == halt_wake_pkg::RELEASE_MODE_SELECT_LEVEL) begin
            release_ev = wake_hi;
          end else begin
            release_ev = wake_rise & ~s_r.blank;
          end
          release_ev = release_ev | key_hit;
          if (release_ev) begin
            // Oscillators start first, per the entry mode
            osc = osc_for(s_r.entry_mode);
            s_nxt.hf_en = osc[1];
            s_nxt.lf_en = osc[0];
            // Warm-up clock follows the entry clock, not the select bit
            s_nxt.src_lf = (s_r.entry_mode == halt_wake_pkg::dual_clock_low_run);
            s_nxt.warm_left = s_r.warm_cnt;
            s_nxt.after_vrst = 1'b0;
            s_nxt.st = halt_wake_pkg::ST_WARM;
          end
        end
      end
      halt_wake_pkg::ST_VRST: begin
        // Held in reset until supply recovers after the blank window
        if (!vd_lo && !s_r.blank) begin
          s_nxt.vd_reset = 1'b0;
          s_nxt.hf_en = 1'b1;
          s_nxt.lf_en = 1'b0;
          s_nxt.src_lf = 1'b0;
          s_nxt.warm_left = s_r.warm_cnt;
          s_nxt.after_vrst = 1'b1;
          s_nxt.st = halt_wake_pkg::ST_WARM;
        end
      end
      halt_wake_pkg::ST_WARM: begin
        // Pins are no longer looked at: falling back cannot re-halt
        if (s_r.mc_cnt == 8'h00) begin
          if (s_r.warm_left == '0) begin
            s_nxt.st = halt_wake_pkg::ST_RUN;
            s_nxt.core_run = 1'b1;
            s_nxt.tg_clear = 1'b1;
            s_nxt.port_hold = 1'b0;
            if (s_r.after_vrst) begin
              s_nxt.mode = halt_wake_pkg::single_clock_high_run;
            end
          end else begin
            s_nxt.warm_left = s_r.warm_left - WARM_W'(1);
          end
        end
      end
      default: s_nxt.st = halt_wake_pkg::ST_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Pin and power-on reset also end halt: come up in single-clock high run
      s_r <= '0;
      s_r.st <= halt_wake_pkg::ST_RUN;
      s_r.mode <= halt_wake_pkg::single_clock_high_run;
      s_r.entry_mode <= halt_wake_pkg::single_clock_high_run;
      s_r.warm_cnt <= halt_wake_pkg::WARM_CNT_RST[WARM_W-1:0];
      s_r.hf_en <= 1'b1;
      s_r.core_run <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign resume_pc = s_r.resume_pc;
  assign core_run = s_r.core_run;
  assign tg_clear = s_r.tg_clear;
  assign port_hold = s_r.port_hold;
  assign hf_osc_en = s_r.hf_en;
  assign lf_osc_en = s_r.lf_en;
  assign warm_src_lf = s_r.src_lf;
  assign vd_reset = s_r.vd_reset;

endmodule

//--- halt_wake_properties.sv
// Concurrent checks on the ports of the halt and wake controller
module halt_wake_properties #(
  parameter int PC_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Release sources
  input wire logic wake_pin,
  input wire logic vd_low,
  // Core and oscillator side
  input wire logic [PC_W-1:0] req_pc,
  input wire logic [PC_W-1:0] resume_pc,
  input wire logic core_run,
  input wire logic tg_clear,
  input wire logic hf_osc_en,
  input wire logic lf_osc_en,
  input wire logic warm_src_lf,
  input wire logic vd_reset
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic wr_ctl; // Control word write completing
  logic [1:0] mode_r; // Run mode seen at the last control write
  assign wr_ctl = psel && penable && pready && pwrite && (paddr == halt_wake_pkg::OFS_SYSCTL);
  // Voltage release falls back to single-clock run, so the mode copy does too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 2'h0;
    end else if (vd_reset) begin
      mode_r <= 2'h0;
    end else if (wr_ctl && core_run) begin
      mode_r <= pwdata[1:0];
    end
  end
  // Warm-up length in pclk cycles; a hang would otherwise pass unnoticed
  localparam logic [10:0] WARM_LIMIT = 11'h44C; // Longest warm-up at the default count, with margin
  logic [10:0] warm_cyc; // Cycles spent with an oscillator on and the core stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_cyc <= 11'h000;
    end else if (core_run || !(hf_osc_en || lf_osc_en)) begin
      // Running, or still halted: no warm-up in progress
      warm_cyc <= 11'h000;
    end else if (warm_cyc != 11'h7FF) begin
      // Saturate so a stuck warm-up keeps the check firing
      warm_cyc <= warm_cyc + 11'h001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_halt_entry;
    wr_ctl && core_run && pwdata[7] && !pwdata[6] |=> !core_run && tg_clear;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("edge halt write not taken");
  property p_stop_all;
    $fell(core_run) |-> !hf_osc_en && !lf_osc_en && tg_clear;
  endproperty
  a_stop_all: assert property (p_stop_all) else $error("oscillators or divider at halt");
  property p_resume_pc;
    $fell(core_run) |-> resume_pc == PC_W'($past(req_pc) + 2);
  endproperty
  a_resume_pc: assert property (p_resume_pc) else $error("held address wrong");
  property p_level_refuse;
    wake_pin [*4] ##0 (wr_ctl && core_run && pwdata[7] && pwdata[6]) |=> core_run;
  endproperty
  a_level_refuse: assert property (p_level_refuse) else $error("halt taken, pin high");
  property p_warm_hold;
    ($rose(hf_osc_en) || $rose(lf_osc_en)) && !core_run |-> !core_run [*4];
  endproperty
  a_warm_hold: assert property (p_warm_hold) else $error("warm-up too short");
  property p_warm_limit;
    warm_cyc <= WARM_LIMIT;
  endproperty
  a_warm_limit: assert property (p_warm_limit) else $error("warm-up never ends");
  property p_osc_mode;
    ($rose(hf_osc_en) || $rose(lf_osc_en)) && !core_run |-> hf_osc_en == (mode_r != 2'h2)
      && lf_osc_en == (mode_r != 2'h0) && warm_src_lf == (mode_r == 2'h2);
  endproperty
  a_osc_mode: assert property (p_osc_mode) else $error("restart oscillators wrong");
  property p_resume_tg;
    $rose(core_run) && $past(presetn) |-> tg_clear;
  endproperty
  a_resume_tg: assert property (p_resume_tg) else $error("no divider clear at resume");
  property p_vd_hold;
    vd_reset && vd_low |=> vd_reset && !core_run && !hf_osc_en;
  endproperty
  a_vd_hold: assert property (p_vd_hold) else $error("voltage reset dropped early");
  property p_apb_answer;
    psel && !penable |=> pready && (pslverr == ($past(paddr) > 12'h00C));
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer wrong");
endmodule

//--- halt_wake_partner.sv
// Behavioural model of the wake pin, key input and supply monitor
module halt_wake_partner (
  // Clock
  input wire logic pclk,
  // Levels asked for by the bench
  input wire logic wake_req,
  input wire logic key_req,
  input wire logic supply_low_req,
  // Pins into the controller
  output logic wake_pin,
  output logic key_pin,
  output logic vd_low
);
  // Quiet pins and healthy supply at power-up
  initial begin
    wake_pin = 1'b0;
    key_pin = 1'b0;
    vd_low = 1'b0;
  end
  // Pins lag requests by an edge and change on the rising edge that the controller samples
  always @(posedge pclk) begin
    wake_pin <= wake_req;
    key_pin <= key_req;
    vd_low <= supply_low_req;
  end
endmodule

//--- halt_mode_wake_control_tb_top.sv
// Self-checking bench for the halt and wake controller
module halt_mode_wake_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC_W = 16;
  localparam logic [11:0] A_CTL = halt_wake_pkg::OFS_SYSCTL;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, wake_pin, key_pin, vd_low, core_run, tg_clear, port_hold;
  logic hf_osc_en, lf_osc_en, warm_src_lf, vd_reset;
  logic wake_req = 1'b0, key_req = 1'b0, supply_low_req = 1'b0;
  logic [PC_W-1:0] req_pc = 16'h0100, resume_pc;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  always #20 pclk = ~pclk; // 25 MHz
  halt_mode_wake_control #(.PC_W(PC_W)) halt_mode_wake_control_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin),
    .key_pin(key_pin), .vd_low(vd_low), .req_pc(req_pc), .resume_pc(resume_pc),
    .core_run(core_run), .tg_clear(tg_clear), .port_hold(port_hold), .hf_osc_en(hf_osc_en),
    .lf_osc_en(lf_osc_en), .warm_src_lf(warm_src_lf), .vd_reset(vd_reset));
  halt_wake_partner halt_wake_partner_inst (.pclk(pclk), .wake_req(wake_req), .key_req(key_req),
    .supply_low_req(supply_low_req), .wake_pin(wake_pin), .key_pin(key_pin), .vd_low(vd_low));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Setup, then access held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends this wait
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait: 0 core_run, 1 any oscillator, 2 voltage reset
  task automatic wait_for(input int which, input logic v);
    int n;
    n = 0;
    while ((which == 0 ? core_run : which == 1 ? (hf_osc_en | lf_osc_en) : vd_reset) !== v
      && n < 3000) begin @(negedge pclk); n++; end
    check(32'(n < 3000), 32'h1);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    apb(1'b0, A_CTL, 32'h0); check(rd, 32'h0);
    apb(1'b0, halt_wake_pkg::OFS_WARMUP, 32'h0); check(rd, 32'h0000_00FF);
    apb(1'b1, halt_wake_pkg::OFS_STATUS, 32'hFFFF_FFFF); // Read-only, must not stick
    apb(1'b0, halt_wake_pkg::OFS_STATUS, 32'h0); check(rd, 32'h0000_0500);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF); check(32'(er), 32'h1);
    apb(1'b0, 12'h010, 32'h0); check({rd[30:0], er}, 32'h1);
    apb(1'b1, halt_wake_pkg::OFS_WARMUP, 32'h2); // Short warm-up for the run
    apb(1'b0, halt_wake_pkg::OFS_WARMUP, 32'h0); check(rd, 32'h2);
    $display("t_regs done");
  endtask
  // Edge release; early pin high, or a rise inside the blank window
  task automatic t_edge(input logic [1:0] mode, input logic early, input logic [2:0] osc);
    @(posedge pclk); wake_req <= early; req_pc <= 16'h0100 + 16'(mode);
    repeat (4) @(posedge pclk);
    fork
      apb(1'b1, A_CTL, 32'hA0 | 32'(mode)); // Edge-mode halt with output hold; the wake pin rises during the write
      begin @(posedge pclk); wake_req <= 1'b1; end
    join
    wait_for(0, 1'b0);
    check(32'(port_hold), 32'h1);
    check(32'(resume_pc), 32'(req_pc + 16'h2));
    check({hf_osc_en, lf_osc_en}, 32'h0);
    check(32'(tg_clear), 32'h1);
    repeat (20) @(negedge pclk);
    check(32'(core_run), 32'h0);
    @(posedge pclk); wake_req <= 1'b0;
    repeat (5) @(posedge pclk); wake_req <= 1'b1;
    wait_for(1, 1'b1);
    check({hf_osc_en, lf_osc_en, warm_src_lf, core_run}, {osc, 1'b0});
    wait_for(0, 1'b1);
    check(32'(tg_clear), 32'h1);
    check(32'(port_hold), 32'h0);
    @(posedge pclk); wake_req <= 1'b0;
    $display("t_edge mode %0d done", mode);
  endtask
  task automatic t_level;
    @(posedge pclk); wake_req <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b1, A_CTL, 32'hC0);
    repeat (4) @(negedge pclk);
    check(32'(core_run), 32'h1);
    @(posedge pclk); wake_req <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b1, A_CTL, 32'hC0);
    wait_for(0, 1'b0);
    repeat (10) @(negedge pclk);
    check(32'(core_run), 32'h0);
    @(posedge pclk); wake_req <= 1'b1;
    wait_for(1, 1'b1);
    @(posedge pclk); wake_req <= 1'b0;
    wait_for(0, 1'b1);
    repeat (20) @(negedge pclk);
    check(32'(core_run), 32'h1);
    $display("t_level done");
  endtask
  task automatic t_key(input logic lvl);
    apb(1'b1, halt_wake_pkg::OFS_WAKECFG, {30'h0, lvl, 1'b1});
    @(posedge pclk); key_req <= !lvl;
    repeat (6) @(posedge pclk);
    apb(1'b1, A_CTL, 32'h80);
    wait_for(0, 1'b0);
    repeat (10) @(negedge pclk);
    check(32'(core_run), 32'h0);
    @(posedge pclk); key_req <= lvl;
    wait_for(1, 1'b1);
    @(posedge pclk); key_req <= !lvl;
    wait_for(0, 1'b1);
    repeat (20) @(negedge pclk);
    check(32'(core_run), 32'h1);
    $display("t_key level %0d done", lvl);
  endtask
  task automatic t_vd;
    apb(1'b1, halt_wake_pkg::OFS_WAKECFG, 32'h4);
    apb(1'b1, A_CTL, 32'h82);
    wait_for(0, 1'b0);
    repeat (8) @(posedge pclk); supply_low_req <= 1'b1;
    wait_for(2, 1'b1);
    repeat (20) @(negedge pclk);
    check({vd_reset, core_run, hf_osc_en, lf_osc_en}, 32'h8);
    @(posedge pclk); supply_low_req <= 1'b0;
    wait_for(1, 1'b1);
    check({hf_osc_en, lf_osc_en}, 32'h2);
    wait_for(0, 1'b1);
    apb(1'b0, A_CTL, 32'h0); check(32'(rd[1:0]), 32'h0);
    $display("t_vd done");
  endtask
  task automatic t_rst;
    apb(1'b1, A_CTL, 32'h81);
    wait_for(0, 1'b0);
    @(posedge pclk); presetn <= 1'b0;
    repeat (2) @(posedge pclk); presetn <= 1'b1;
    @(negedge pclk);
    check({core_run, hf_osc_en, lf_osc_en}, 32'h6);
    $display("t_rst done");
  endtask
  // ----------------------------------------
  // Sequence, timeout and verdict
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Whole run is a few hundred cycles; the ceiling leaves a wide margin
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_edge(2'h0, 1'b0, 3'b100);
    t_edge(2'h1, 1'b1, 3'b110);
    t_edge(2'h2, 1'b0, 3'b011);
    t_level;
    t_key(1'b0);
    t_key(1'b1);
    t_vd;
    t_rst;
    final_report;
  end
endmodule
bind halt_mode_wake_control halt_wake_properties #(.PC_W(PC_W)) halt_wake_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin),
  .vd_low(vd_low), .req_pc(req_pc), .resume_pc(resume_pc), .core_run(core_run),
  .tg_clear(tg_clear), .hf_osc_en(hf_osc_en), .lf_osc_en(lf_osc_en),
  .warm_src_lf(warm_src_lf), .vd_reset(vd_reset));
